//--- fsr_consts.svh
// fsr_consts.svh: constants of the four-stage synchronous shift register
// assumes: included by its bare name from the package and the design module
`ifndef FSR_CONSTS_SVH
`define FSR_CONSTS_SVH

`define FSR_STAGES      4
`define FSR_STAGE_RST   4'h0
`define FSR_PINS_RST    9'h000
`define FSR_CTL_HOLD    2'h0
`define FSR_CTL_SHR     2'h1
`define FSR_CTL_LOAD    2'h2
`define FSR_CTL_SHR_ALT 2'h3
`define FSR_BUF_DEPTH   2
`define FSR_CNT_EMPTY   2'h0
`define FSR_CNT_ONE     2'h1
`define FSR_CNT_FULL    2'h2
`define FSR_PTR_RST     1'h0

`endif

//--- fsr_pkg.sv
// fsr_pkg.sv: types of the four-stage synchronous shift register
// assumes: fsr_consts.svh is on the include path
`include "fsr_consts.svh"

package fsr_pkg;

	// control decode of {load, shift}
	typedef enum logic [1:0] {
		FSR_HOLD    = `FSR_CTL_HOLD,
		FSR_SHR     = `FSR_CTL_SHR,
		FSR_SHR_ALT = `FSR_CTL_SHR_ALT,
		FSR_LOAD    = `FSR_CTL_LOAD
	} fsr_ctl_type;

	// all pins from the surrounding logic, travelling together
	typedef struct packed {
		logic                     clk;
		logic                     clear_n;
		logic                     load;
		logic                     shift;
		logic                     serial;
		logic [`FSR_STAGES-1:0]   par;
	} fsr_pins_type;

endpackage

//--- fsr_shift_register.sv
// fsr_shift_register.sv: four-stage shift register with clear, inverse output and a result buffer
// assumes: pins come from outside the clock_i domain; out_ready_i is on clock_i
`timescale 1ns/1ns
`include "fsr_consts.svh"

module fsr_shift_register (
	// clock and reset
	input  wire logic                   clock_i,
	input  wire logic                   sys_rst_i,
	// register pins from the surrounding logic
	input  wire logic                   shift_clk_i,
	input  wire logic                   clear_n_i,
	input  wire logic                   load_i,
	input  wire logic                   shift_i,
	input  wire logic                   serial_i,
	input  wire logic [`FSR_STAGES-1:0] par_i,
	// stage outputs
	output logic      [`FSR_STAGES-1:0] stage_o,
	output logic                        serial_o,
	output logic                        serial_n_o,
	// buffered result stream
	output logic                        out_valid_o,
	output logic      [`FSR_STAGES-1:0] out_data_o,
	input  wire logic                   out_ready_i
);

	fsr_pkg::fsr_pins_type         pins_raw;
	fsr_pkg::fsr_pins_type         pins_s1_q;
	fsr_pkg::fsr_pins_type         pins_s1_d;
	fsr_pkg::fsr_pins_type         pins_s2_q;
	fsr_pkg::fsr_pins_type         pins_s2_d;
	logic                          clk_s3_q;
	logic                          clk_s3_d;
	logic                          fall_edge;
	logic                          pend_q;
	logic                          pend_d;
	fsr_pkg::fsr_pins_type         pend_cmd_q;
	fsr_pkg::fsr_pins_type         pend_cmd_d;
	logic                          apply;
	logic [`FSR_STAGES-1:0]        stage_q;
	logic [`FSR_STAGES-1:0]        stage_d;
	logic [`FSR_STAGES-1:0]        buf_q [`FSR_BUF_DEPTH];
	logic [`FSR_STAGES-1:0]        buf_d [`FSR_BUF_DEPTH];
	logic                          wr_ptr_q;
	logic                          wr_ptr_d;
	logic                          rd_ptr_q;
	logic                          rd_ptr_d;
	logic [1:0]                    count_q;
	logic [1:0]                    count_d;
	logic [`FSR_STAGES-1:0]        out_data_q;
	logic [`FSR_STAGES-1:0]        out_data_d;
	logic                          buf_in_ready;
	logic                          push;
	logic                          pop;

	// action taken on one falling edge
	function automatic logic [`FSR_STAGES-1:0] next_stage(input logic [`FSR_STAGES-1:0] cur,
		input fsr_pkg::fsr_pins_type cmd);
		fsr_pkg::fsr_ctl_type ctl;
		ctl = fsr_pkg::fsr_ctl_type'({cmd.load, cmd.shift});
		case (ctl)
			fsr_pkg::FSR_HOLD: begin
				next_stage = cur;
			end
			fsr_pkg::FSR_SHR, fsr_pkg::FSR_SHR_ALT: begin
				next_stage = {cur[`FSR_STAGES-2:0], cmd.serial};
			end
			fsr_pkg::FSR_LOAD: begin
				next_stage = cmd.par;
			end
			default: begin
				next_stage = cur;
			end
		endcase
	endfunction

	// two-flop synchroniser for all pins, third flop for edge detection
	assign pins_raw = '{clk: shift_clk_i, clear_n: clear_n_i, load: load_i, shift: shift_i,
		serial: serial_i, par: par_i};

	always_comb begin
		pins_s1_d = pins_raw;
		pins_s2_d = pins_s1_q;
		clk_s3_d  = pins_s2_q.clk;
	end

	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			pins_s1_q <= `FSR_PINS_RST;
			pins_s2_q <= `FSR_PINS_RST;
			clk_s3_q  <= 1'h0;
		end else begin
			pins_s1_q <= pins_s1_d;
			pins_s2_q <= pins_s2_d;
			clk_s3_q  <= clk_s3_d;
		end
	end

	// only the falling transition starts an action
	assign fall_edge = clk_s3_q & ~pins_s2_q.clk;

	// edge waits here while the result buffer is full
	assign apply = pend_q & buf_in_ready;

	always_comb begin
		pend_d     = pend_q;
		pend_cmd_d = pend_cmd_q;
		if (fall_edge) begin
			pend_d     = 1'h1;
			pend_cmd_d = pins_s2_q;
		end else if (apply) begin
			pend_d = 1'h0;
		end
	end

	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			pend_q     <= 1'h0;
			pend_cmd_q <= `FSR_PINS_RST;
		end else begin
			pend_q     <= pend_d;
			pend_cmd_q <= pend_cmd_d;
		end
	end

	// stages: clocked action wins over clear in its cycle
	always_comb begin
		stage_d = stage_q;
		if (apply) begin
			stage_d = next_stage(stage_q, pend_cmd_q);
		end else if (!pins_s2_q.clear_n) begin
			stage_d = `FSR_STAGE_RST;
		end
	end

	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			stage_q <= `FSR_STAGE_RST;
		end else begin
			stage_q <= stage_d;
		end
	end

	assign stage_o    = stage_q;
	assign serial_o   = stage_q[`FSR_STAGES-1];
	assign serial_n_o = ~stage_q[`FSR_STAGES-1];

	// two-entry result buffer
	assign buf_in_ready = (count_q != `FSR_CNT_FULL);
	assign push         = apply;
	assign pop          = out_ready_i & (count_q != `FSR_CNT_EMPTY);
	assign out_valid_o  = (count_q != `FSR_CNT_EMPTY);
	assign out_data_o   = out_data_q;

	always_comb begin
		buf_d    = buf_q;
		wr_ptr_d = wr_ptr_q;
		rd_ptr_d = rd_ptr_q;
		count_d  = count_q;
		if (push) begin
			buf_d[wr_ptr_q] = stage_d;
			wr_ptr_d        = ~wr_ptr_q;
		end
		if (pop) begin
			rd_ptr_d = ~rd_ptr_q;
		end
		if (push && !pop) begin
			count_d = count_q + `FSR_CNT_ONE;
		end else if (pop && !push) begin
			count_d = count_q - `FSR_CNT_ONE;
		end
		if (count_d == `FSR_CNT_EMPTY) begin
			out_data_d = `FSR_STAGE_RST;
		end else if (count_q == `FSR_CNT_EMPTY || (count_q == `FSR_CNT_ONE && pop)) begin
			out_data_d = stage_d;
		end else begin
			out_data_d = buf_q[rd_ptr_d];
		end
	end

	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			buf_q[0]   <= `FSR_STAGE_RST;
			buf_q[1]   <= `FSR_STAGE_RST;
			wr_ptr_q   <= `FSR_PTR_RST;
			rd_ptr_q   <= `FSR_PTR_RST;
			count_q    <= `FSR_CNT_EMPTY;
			out_data_q <= `FSR_STAGE_RST;
		end else begin
			buf_q      <= buf_d;
			wr_ptr_q   <= wr_ptr_d;
			rd_ptr_q   <= rd_ptr_d;
			count_q    <= count_d;
			out_data_q <= out_data_d;
		end
	end

	// checks
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (sys_rst_i);

	sequence s_fall_seen;
		fall_edge;
	endsequence

	sequence s_pend_next;
		##1 pend_q;
	endsequence

	a_edge_pending: assert property (s_fall_seen |-> s_pend_next)
		else $error("falling edge not held as pending");
	a_no_idle_change: assert property ((!apply && pins_s2_q.clear_n) |=> $stable(stage_q))
		else $error("stages changed without an edge");
	a_hold_mode: assert property ((apply && !pend_cmd_q.load && !pend_cmd_q.shift) |=> $stable(stage_q))
		else $error("hold mode changed stages");
	a_shift_mode: assert property ((apply && pend_cmd_q.shift) |=>
		stage_q == {$past(stage_q[2:0]), $past(pend_cmd_q.serial)})
		else $error("shift right gave wrong stages");
	a_load_mode: assert property ((apply && pend_cmd_q.load && !pend_cmd_q.shift) |=>
		stage_q == $past(pend_cmd_q.par))
		else $error("parallel load gave wrong stages");
	a_clear_zero: assert property ((!apply && !pins_s2_q.clear_n) |=> stage_q == 4'h0)
		else $error("clear did not zero stages");
	a_clear_yields: assert property ((apply && !pins_s2_q.clear_n && pend_cmd_q.load && !pend_cmd_q.shift)
		|=> stage_q == $past(pend_cmd_q.par))
		else $error("clear overrode a clocked load");
	a_inverse_out: assert property (serial_n_o != stage_o[3])
		else $error("inverse output wrong");
	a_serial_out: assert property (serial_o == stage_o[3])
		else $error("serial output is not fourth stage");
	a_full_stalls: assert property ((pend_q && count_q == 2'h2 && !pop) |=> pend_q)
		else $error("edge lost while buffer full");

	// last word pushed, for the buffer order checks
	logic [`FSR_STAGES-1:0]        last_push_q;
	logic [`FSR_STAGES-1:0]        last_push_d;

	always_comb begin
		last_push_d = last_push_q;
		if (push) begin
			last_push_d = stage_d;
		end
	end

	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			last_push_q <= `FSR_STAGE_RST;
		end else begin
			last_push_q <= last_push_d;
		end
	end

	sequence s_idle_fall;
		fall_edge && (count_q == `FSR_CNT_EMPTY) && !pend_q;
	endsequence

	sequence s_word_lands;
		##1 apply ##1 out_valid_o;
	endsequence

	sequence s_pin_rise;
		!clk_s3_q && pins_s2_q.clk && !pend_q && pins_s2_q.clear_n;
	endsequence

	sequence s_head_stalled;
		out_valid_o && !out_ready_i;
	endsequence

	a_edge_lands: assert property (s_idle_fall |-> s_word_lands)
		else $error("edge into empty buffer did not land");
	a_rise_ignored: assert property (s_pin_rise |=> $stable(stage_q))
		else $error("stages changed on a rising transition");
	a_rise_no_fall: assert property ($rose(pins_s2_q.clk) |-> !fall_edge)
		else $error("rising transition seen as an edge");
	a_fall_detect: assert property ($fell(pins_s2_q.clk) |-> fall_edge)
		else $error("falling transition missed");
	a_sync_two: assert property (fall_edge |-> (!$past(shift_clk_i, 2) && $past(shift_clk_i, 3)))
		else $error("edge not taken through two flops");
	a_pend_clears: assert property ((apply && !fall_edge) |=> !pend_q)
		else $error("applied edge still pending");
	a_stall_keeps: assert property ((pend_q && !apply && !fall_edge) |=> $stable(pend_cmd_q))
		else $error("waiting command disturbed");

	a_push_valid: assert property (push |=> out_valid_o)
		else $error("pushed word not valid");
	a_empty_zero: assert property (!out_valid_o |-> out_data_o == `FSR_STAGE_RST)
		else $error("empty buffer shows data");
	a_head_holds: assert property (s_head_stalled |=> out_valid_o && $stable(out_data_o))
		else $error("head word changed while stalled");
	a_single_order: assert property ((count_q == `FSR_CNT_ONE) |-> out_data_o == last_push_q)
		else $error("single word is not the last pushed");
	a_pop_next: assert property ((count_q == `FSR_CNT_FULL && pop) |=> out_data_o == last_push_q)
		else $error("pop from full gave wrong word");
	a_pop_drains: assert property ((count_q == `FSR_CNT_ONE && pop && !push) |=> !out_valid_o)
		else $error("last pop left buffer valid");
	a_load_pushes: assert property ((apply && pend_cmd_q.load && !pend_cmd_q.shift) |=>
		last_push_q == $past(pend_cmd_q.par))
		else $error("loaded word not pushed");
	a_full_no_push: assert property ((count_q == `FSR_CNT_FULL) |-> !push)
		else $error("push into full buffer");
	a_count_bound: assert property (count_q != 2'h3)
		else $error("buffer count beyond depth");
	a_reset_state: assert property (@(posedge clock_i) disable iff (1'b0)
		sys_rst_i |=> (stage_q == `FSR_STAGE_RST && !out_valid_o && !pend_q))
		else $error("reset left state behind");

endmodule

//--- fsr_src_model.sv
// fsr_src_model.sv: surrounding logic that drives the register pins, one clock fall per command
// assumes: start_i is held for one clock_i cycle while busy_o is low
`timescale 1ns/1ns
module fsr_src_model (
	// clock and reset
	input  wire logic                  clock_i,
	input  wire logic                  sys_rst_i,
	// command from the bench
	input  wire logic                  start_i,
	input  wire fsr_pkg::fsr_pins_type cmd_i,
	// pins toward the register, busy flag toward the bench
	output fsr_pkg::fsr_pins_type      pins_o,
	output logic                       busy_o
);
	logic [3:0] cnt_q;

	always_ff @(negedge clock_i) begin
		if (sys_rst_i) begin
			pins_o <= 9'h180;
			cnt_q  <= 4'h0;
			busy_o <= 1'b0;
		end else if (!busy_o) begin
			if (start_i) begin
				pins_o <= cmd_i;
				cnt_q  <= 4'h1;
				busy_o <= 1'b1;
			end else begin
				// data lines are not held between commands
				pins_o.par    <= ~pins_o.par;
				pins_o.serial <= ~pins_o.serial;
			end
		end else begin
			cnt_q <= cnt_q + 4'h1;
			if (cnt_q == 4'h4)
				pins_o.clk <= 1'b0;
			if (cnt_q == 4'h8)
				pins_o.clk <= 1'b1;
			if (cnt_q == 4'hC)
				busy_o <= 1'b0;
		end
	end
endmodule

//--- fsr_shift_register_tb.sv
// fsr_shift_register_tb.sv: self-checking bench of the four-stage shift register
// assumes: fsr_pkg and fsr_src_model are compiled first
`timescale 1ns/1ns
module fsr_shift_register_tb;
	logic                  clock_i;
	logic                  sys_rst_i;
	logic                  start;
	logic                  out_ready;
	fsr_pkg::fsr_pins_type cmd;
	fsr_pkg::fsr_pins_type pins;
	logic                  busy;
	logic [3:0]            stage;
	logic                  ser;
	logic                  ser_n;
	logic                  vld;
	logic [3:0]            dat;
	logic [3:0]            q[$];
	int                    bad_count;
	int                    tests_run;
	int                    cyc;

	fsr_src_model src (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .start_i(start), .cmd_i(cmd),
		.pins_o(pins), .busy_o(busy));
	fsr_shift_register uut (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .shift_clk_i(pins.clk),
		.clear_n_i(pins.clear_n), .load_i(pins.load), .shift_i(pins.shift), .serial_i(pins.serial),
		.par_i(pins.par), .stage_o(stage), .serial_o(ser), .serial_n_o(ser_n), .out_valid_o(vld),
		.out_data_o(dat), .out_ready_i(out_ready));

	initial begin
		clock_i = 1'b0;
		forever #4 clock_i = ~clock_i;
	end

	task automatic end_sim;
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	always @(posedge clock_i) begin
		cyc++;
		if (cyc == 5000) begin
			bad_count++;
			end_sim();
		end
	end

	task automatic chk(string n, logic [3:0] s, logic [3:0] x);
		tests_run++;
		if (s !== x) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", n, x, s);
		end
	endtask

	function automatic fsr_pkg::fsr_pins_type mk(logic c, logic l, logic s, logic d, logic [3:0] p);
		mk = '{1'b1, c, l, s, d, p};
	endfunction

	task automatic take;
		int n;
		for (n = 0; n < 30 && vld !== 1'b1; n++)
			@(negedge clock_i);
		chk("valid", {3'h0, vld}, 4'h1);
		chk("word", dat, q.pop_front());
		out_ready <= 1'b1;
		@(negedge clock_i);
		out_ready <= 1'b0;
		@(negedge clock_i);
	endtask

	task automatic t_reset;
		chk("reset stage", stage, 4'h0);
		chk("reset inverse", {3'h0, ser_n}, 4'h1);
		chk("reset valid", {3'h0, vld}, 4'h0);
		chk("reset data", dat, 4'h0);
	endtask

	task automatic apply(fsr_pkg::fsr_pins_type c, logic [3:0] x, logic pop);
		int n;
		@(negedge clock_i);
		cmd   <= c;
		start <= 1'b1;
		@(negedge clock_i);
		start <= 1'b0;
		@(negedge clock_i);
		for (n = 0; n < 40 && busy !== 1'b0; n++)
			@(negedge clock_i);
		q.push_back(x);
		if (pop) begin
			chk("stage", stage, x);
			chk("serial", {3'h0, ser}, {3'h0, x[3]});
			chk("inverse", {3'h0, ser_n}, {3'h0, ~x[3]});
			take();
		end
	endtask

	task automatic t_modes;
		apply(mk(1, 1, 0, 0, 4'hA), 4'hA, 1);
		apply(mk(1, 0, 0, 1, 4'h5), 4'hA, 1);
		apply(mk(1, 0, 1, 1, 4'h0), 4'h5, 1);
		apply(mk(1, 1, 1, 0, 4'hF), 4'hA, 1);
	endtask

	task automatic t_chain;
		logic [7:0] pat;
		logic [3:0] e;
		logic [3:0] f;
		logic       so;
		pat = 8'hB4;
		e   = stage;
		f   = 4'h0;
		for (int i = 7; i >= 0; i--) begin
			so = ser;
			e  = {e[2:0], pat[i]};
			apply(mk(1, 0, 1, pat[i], 4'h0), e, 1);
			f = {f[2:0], so};
		end
		chk("chain", f, 4'hB);
	endtask

	task automatic t_clear;
		apply(mk(0, 1, 0, 0, 4'h9), 4'h9, 0);
		take();
		repeat (4) @(negedge clock_i);
		chk("clear", stage, 4'h0);
		apply(mk(1, 0, 0, 0, 4'h0), 4'h0, 1);
	endtask

	task automatic t_stall;
		apply(mk(1, 1, 0, 0, 4'h3), 4'h3, 0);
		apply(mk(1, 1, 0, 0, 4'h5), 4'h5, 0);
		apply(mk(1, 1, 0, 0, 4'h6), 4'h6, 0);
		repeat (6) @(negedge clock_i);
		chk("stall", stage, 4'h5);
		take();
		take();
		take();
		chk("last", stage, 4'h6);
	endtask

	initial begin
		sys_rst_i = 1'b1;
		start     = 1'b0;
		out_ready = 1'b0;
		cmd       = mk(1, 0, 0, 0, 4'h0);
		bad_count = 0;
		tests_run = 0;
		cyc       = 0;
		repeat (16) @(negedge clock_i);
		sys_rst_i <= 1'b0;
		repeat (4) @(negedge clock_i);
		t_reset();
		t_modes();
		t_chain();
		t_clear();
		t_stall();
		end_sim();
	end
endmodule
